/* File: core/tfsr_pkg.sv */
// ----------------------------------------------------------------------------
// shared constants and carriers for the tunable filter state registers
// ----------------------------------------------------------------------------
package tfsr_pkg;

  // --------------------------------------------------------------------------
  // geometry
  // --------------------------------------------------------------------------
  localparam int ADDR_W = 10;            // register address width
  localparam int DATA_W = 8;             // register data width
  localparam int IDX_W = 7;              // table index width
  localparam int TABLE_DEPTH = 128;      // number of table entries

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CLASS = 10'h003;
  localparam logic [ADDR_W-1:0] OFS_PART_LOW = 10'h004;
  localparam logic [ADDR_W-1:0] OFS_PART_HIGH = 10'h005;
  localparam logic [ADDR_W-1:0] OFS_STOP = 10'h011;
  localparam logic [ADDR_W-1:0] OFS_START = 10'h012;
  localparam logic [ADDR_W-1:0] OFS_DIR = 10'h013;
  localparam logic [ADDR_W-1:0] OFS_POINTER = 10'h014;
  localparam logic [ADDR_W-1:0] OFS_DIRECT = 10'h020;
  localparam logic [ADDR_W-1:0] OFS_TABLE_FIRST = 10'h100;
  localparam logic [ADDR_W-1:0] OFS_TABLE_LAST = 10'h17F;

  // --------------------------------------------------------------------------
  // reset values and encodings
  // --------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] STOP_RST = 7'h7F;
  localparam logic [IDX_W-1:0] START_RST = 7'h00;
  localparam logic [IDX_W-1:0] PTR_RST = 7'h00;
  localparam logic DIR_RST = 1'b0;
  localparam logic DIR_INC = 1'b0;       // pointer counts up
  localparam logic DIR_DEC = 1'b1;       // pointer counts down
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic RESV_BIT = 1'b0;      // value of a reserved bit on read
  localparam logic [IDX_W-1:0] IDX_ONE = 7'h01;

  // --------------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------------
  // one state pair: high-pass section in the upper nibble
  typedef struct packed {
    logic [3:0] highpass_section;
    logic [3:0] lowpass_section;
  } tfsr_filt_t;

  // one register request from the serial host decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } tfsr_req_t;

endpackage

/* File: core/tfsr_regs.sv */
// Behaviour
// - read-only device class code, writes ignored
// - 16-bit part code at 0x004 low, 0x005 high
// - 7-bit stop index, reset 0x7F, bit7 reserved
// - 7-bit start index, reset zero, bit7 reserved
// - direction bit: 0 increments, 1 decrements
// - read-only pointer readback, resets to zero
// - direct register: high-pass [7:4], low-pass [3:0]
// - 128 read/write table entries 0x100..0x17F
`timescale 1ns/1ps
`default_nettype none
module tfsr_regs
  import tfsr_pkg::*;
#(
  parameter logic [7:0] CLASS_CODE = 8'h5A,     // arbitrary value
  parameter logic [7:0] PART_CODE_LOW = 8'h3C,  // arbitrary value
  parameter logic [7:0] PART_CODE_HIGH = 8'hC6, // arbitrary value
  parameter int DEPTH = TABLE_DEPTH             // table entries
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register port from the serial host decoder
  input wire tfsr_req_t req,
  output logic [DATA_W-1:0] rdata,
  output logic rvalid,
  // sequencing trigger pin
  input wire logic seq_trig_pin,
  // state driven to both filter sections
  output tfsr_filt_t filt
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [IDX_W-1:0] stop;              // last table index used
    logic [IDX_W-1:0] start;             // first table index used
    logic dir;                           // stepping direction
    logic [IDX_W-1:0] ptr;               // sequencing pointer
    tfsr_filt_t direct;                  // direct-write register
    tfsr_filt_t applied;                 // state presented to the filters
    tfsr_filt_t [DEPTH-1:0] table_mem;   // sequencing table
    logic trig_prev;                     // last synchronised trigger level
    logic [DATA_W-1:0] rdata;            // read answer
    logic rvalid;                        // read answer marker
  } tfsr_st_t;

  tfsr_st_t s_q;
  tfsr_st_t s_d;
  logic trig_sync;                       // trigger after two flip-flops
  logic trig_rise;                       // one-cycle trigger event

  // --------------------------------------------------------------------------
  // decode helpers
  // --------------------------------------------------------------------------
  // true when the address falls in the table window
  function automatic logic is_table(input logic [ADDR_W-1:0] a);
    return (a >= OFS_TABLE_FIRST) && (a <= OFS_TABLE_LAST);
  endfunction

  // table index of an address inside the window
  function automatic logic [IDX_W-1:0] table_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - OFS_TABLE_FIRST;
    return d[IDX_W-1:0];
  endfunction

  // --------------------------------------------------------------------------
  // trigger pin crossing
  // --------------------------------------------------------------------------
  tfsr_sync #(
    .W(1)
  ) u_trig_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .async_in(seq_trig_pin),
    .sync_out(trig_sync)
  );

  // edge seen only after the second stage
  assign trig_rise = trig_sync && !s_q.trig_prev;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.trig_prev = trig_sync;
    s_d.rvalid = 1'b0;
    // sequencing step uses the table as it stood before any write this cycle
    if (trig_rise) begin
      s_d.applied = s_q.table_mem[s_q.ptr];
      if (s_q.dir == DIR_INC) begin
        // past the stop index the pointer goes back to start
        s_d.ptr = (s_q.ptr == s_q.stop) ? s_q.start : s_q.ptr + IDX_ONE;
      end else begin
        // below the start index the pointer goes back to stop
        s_d.ptr = (s_q.ptr == s_q.start) ? s_q.stop : s_q.ptr - IDX_ONE;
      end
    end
    // register writes; identity and pointer registers have no write path
    if (req.wr) begin
      if (is_table(req.addr)) begin
        s_d.table_mem[table_idx(req.addr)] = req.wdata;
      end else begin
        case (req.addr)
          OFS_STOP: begin
            s_d.stop = req.wdata[IDX_W-1:0];
          end
          OFS_START: begin
            // restarting from the new start keeps the pointer in range
            s_d.start = req.wdata[IDX_W-1:0];
            s_d.ptr = req.wdata[IDX_W-1:0];
          end
          OFS_DIR: begin
            s_d.dir = req.wdata[0];
          end
          OFS_DIRECT: begin
            // a direct write takes the filters over at once, over a trigger
            s_d.direct = req.wdata;
            s_d.applied = req.wdata;
          end
          default: begin
            // read-only or unmapped: write ignored
            s_d.direct = s_q.direct;
          end
        endcase
      end
    end
    // register reads; answer one cycle later
    if (req.rd) begin
      s_d.rvalid = 1'b1;
      if (is_table(req.addr)) begin
        s_d.rdata = s_q.table_mem[table_idx(req.addr)];
      end else begin
        case (req.addr)
          OFS_CLASS: s_d.rdata = CLASS_CODE;
          OFS_PART_LOW: s_d.rdata = PART_CODE_LOW;
          OFS_PART_HIGH: s_d.rdata = PART_CODE_HIGH;
          OFS_STOP: s_d.rdata = {RESV_BIT, s_q.stop};
          OFS_START: s_d.rdata = {RESV_BIT, s_q.start};
          OFS_DIR: s_d.rdata = {7'h00, s_q.dir};
          OFS_POINTER: s_d.rdata = {RESV_BIT, s_q.ptr};
          OFS_DIRECT: s_d.rdata = s_q.direct;
          default: s_d.rdata = BYTE_ZERO;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  // table, filters and pointer clear to zero; stop index has its own value
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.stop <= STOP_RST;
      s_q.start <= START_RST;
      s_q.dir <= DIR_RST;
      s_q.ptr <= PTR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign rvalid = s_q.rvalid;
  assign filt = s_q.applied;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  // a lone read of one address
  sequence sq_rd(logic [ADDR_W-1:0] a);
    req.rd && !req.wr && (req.addr == a);
  endsequence

  // a write to one address
  sequence sq_wr(logic [ADDR_W-1:0] a);
    req.wr && !req.rd && (req.addr == a) && !trig_rise;
  endsequence

  AST_CLASS_RO: assert property (
    sq_wr(OFS_CLASS) ##1 sq_rd(OFS_CLASS) |=> rvalid && (rdata == CLASS_CODE))
    else $error("class code read wrong");

  AST_PART_CODE: assert property (
    sq_rd(OFS_PART_LOW) ##1 sq_rd(OFS_PART_HIGH)
      |-> (rdata == PART_CODE_LOW) ##1 (rdata == PART_CODE_HIGH))
    else $error("part code bytes wrong");

  AST_STOP_RW: assert property (
    sq_wr(OFS_STOP) ##1 sq_rd(OFS_STOP) |=> rdata == {RESV_BIT, $past(req.wdata[6:0], 2)})
    else $error("stop index readback wrong");

  AST_START_RW: assert property (
    sq_wr(OFS_START) ##1 sq_rd(OFS_START) |=> rdata == {RESV_BIT, $past(req.wdata[6:0], 2)})
    else $error("start index readback wrong");

  AST_STEP_INC: assert property (
    trig_rise && !req.wr && (s_q.dir == DIR_INC) && (s_q.ptr != s_q.stop)
      |=> s_q.ptr == $past(s_q.ptr) + IDX_ONE)
    else $error("increment step wrong");

  AST_STEP_DEC: assert property (
    trig_rise && !req.wr && (s_q.dir == DIR_DEC) && (s_q.ptr != s_q.start)
      |=> s_q.ptr == $past(s_q.ptr) - IDX_ONE)
    else $error("decrement step wrong");

  AST_PTR_READ: assert property (
    sq_rd(OFS_POINTER) |=> rvalid && (rdata == {RESV_BIT, $past(s_q.ptr)}))
    else $error("pointer readback wrong");

  // the state stands a further cycle unless a trigger or another write took over
  AST_DIRECT_APPLY: assert property (
    sq_wr(OFS_DIRECT) |=> (filt == $past(req.wdata))
      ##1 ($past(trig_rise) || $past(req.wr) || (filt == $past(req.wdata, 2))))
    else $error("direct state not applied");

  AST_TABLE_RW: assert property (
    (req.wr && !req.rd && is_table(req.addr))
      ##1 (req.rd && !req.wr && (req.addr == $past(req.addr)))
      |=> rdata == $past(req.wdata, 2))
    else $error("table readback wrong");

  AST_TRIG_APPLY: assert property (
    trig_rise && !req.wr |=> filt == $past(s_q.table_mem[s_q.ptr]))
    else $error("table entry not applied");

  AST_WRAP: assert property (
    trig_rise && !req.wr && (s_q.dir == DIR_INC) && (s_q.ptr == s_q.stop)
      |=> s_q.ptr == $past(s_q.start))
    else $error("pointer did not wrap to start");

  AST_RESV_ZERO: assert property (
    sq_rd(OFS_DIR) |=> rdata[7:1] == 7'h00)
    else $error("reserved bits not zero");

endmodule
`default_nettype wire

/* File: core/tfsr_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// two flip-flop synchroniser for pins from outside the clock domain
// ----------------------------------------------------------------------------
module tfsr_sync
  import tfsr_pkg::*;
#(
  parameter int W = 1                    // number of bits synchronised
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // asynchronous side
  input wire logic [W-1:0] async_in,
  // synchronised side
  output logic [W-1:0] sync_out
);

  // both stages live in one state word
  typedef struct packed {
    logic [W-1:0] meta;                  // first stage, read only by second
    logic [W-1:0] stable;                // second stage
  } tfsr_sync_st_t;

  tfsr_sync_st_t s_q;
  tfsr_sync_st_t s_d;

  // next state: shift the pin through both stages
  always_comb begin
    s_d = s_q;
    s_d.meta = async_in;
    s_d.stable = s_q.meta;
  end

  // state register, synchronous reset to zero
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule
`default_nettype wire

/* File: tb/tfsr_trig_src.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// trigger source standing at the far side of the sequencing pin
// ----------------------------------------------------------------------------
module tfsr_trig_src (
  // command from the bench
  input wire logic go,
  // pin towards the register bank
  output logic pin
);
  // pin is low outside a pulse; each pulse on a rising go holds it high for 160 ns
  initial begin
    pin = 1'b0;
  end
  // offset of 7 ns keeps the pin edge away from the 40 ns clock edges,
  // so the synchroniser really sees an unrelated phase
  always @(posedge go) begin
    #7 pin = 1'b1;
    #160 pin = 1'b0;
  end
endmodule
`default_nettype wire

/* File: tb/tunable_filter_state_regs_bench.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------------
// self-checking bench for the filter state register bank
// ----------------------------------------------------------------------------
module tunable_filter_state_regs_bench
  import tfsr_pkg::*;
;
  logic clock; // 25 MHz system clock
  logic sys_rst; // synchronous reset
  tfsr_req_t req; // register request
  logic [DATA_W-1:0] rdata; // read answer
  logic rvalid; // read answer marker
  logic seq_trig_pin; // trigger from the far side
  tfsr_filt_t filt; // state driven to both sections
  logic go; // asks the trigger source for one pulse
  int err_total; // mismatches seen
  int checks; // comparisons made
  logic [7:0] shadow [TABLE_DEPTH]; // expected table contents
  logic [IDX_W-1:0] ptr; // expected engine pointer
  logic [IDX_W-1:0] s_lo; // expected start index
  logic [IDX_W-1:0] s_hi; // expected stop index

  // --------------------------------------------------------------------------
  // design and far side
  // --------------------------------------------------------------------------
  tfsr_regs tfsr_regs_i (
    .clock(clock),
    .sys_rst(sys_rst),
    .req(req),
    .rdata(rdata),
    .rvalid(rvalid),
    .seq_trig_pin(seq_trig_pin),
    .filt(filt)
  );
  tfsr_trig_src tfsr_trig_src_i (
    .go(go),
    .pin(seq_trig_pin)
  );

  // clock generator
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  // compare one byte, counting every call
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one read: request for one cycle, answer lands one cycle later
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clock);
    #1 req.rd = 1'b1;
    req.addr = a;
    @(posedge clock);
    #1 req.rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
  endtask
  // one write: takes effect at the edge that samples it
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock);
    #1 req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge clock);
    #1 req.wr = 1'b0;
  endtask
  // write, then read the same place on the very next edge, no gap cycle
  task automatic wrrd(
    input logic [ADDR_W-1:0] a,
    input logic [7:0] d,
    input logic [7:0] exp
  );
    @(posedge clock);
    #1 req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(posedge clock);
    #1 req.wr = 1'b0;
    req.rd = 1'b1;
    @(posedge clock);
    #1 req.rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
  endtask
  // two reads on consecutive edges; the strobe stays up across both
  task automatic rd2(
    input logic [ADDR_W-1:0] a1,
    input logic [ADDR_W-1:0] a2,
    input logic [7:0] exp1,
    input logic [7:0] exp2
  );
    @(posedge clock);
    #1 req.rd = 1'b1;
    req.addr = a1;
    @(posedge clock);
    #1 req.addr = a2;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp1);
    @(posedge clock);
    #1 req.rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp2);
  endtask
  // one pin pulse; the wait covers the synchroniser and the low gap
  task automatic trig(input logic dec);
    @(posedge clock);
    #1 go = 1'b1;
    repeat (10) @(posedge clock);
    #1 go = 1'b0;
    check(filt, shadow[ptr]);
    if (dec == DIR_INC) begin
      ptr = (ptr == s_hi) ? s_lo : ptr + 7'h01;
    end else begin
      ptr = (ptr == s_lo) ? s_hi : ptr - 7'h01;
    end
    rdchk(OFS_POINTER, {1'b0, ptr});
  endtask
  // verdict, reached from the tests and from the watchdog
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // watchdog: the tests need well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    complete_run();
  end

  // --------------------------------------------------------------------------
  // tests
  // --------------------------------------------------------------------------
  initial begin
    err_total = 0;
    checks = 0;
    sys_rst = 1'b1;
    req = '0;
    go = 1'b0;
    ptr = PTR_RST;
    repeat (6) @(posedge clock);
    #1 sys_rst = 1'b0;
    // reset values and identity bytes
    check(filt, BYTE_ZERO);
    rdchk(OFS_CLASS, 8'h5A);
    rdchk(OFS_PART_LOW, 8'h3C);
    rdchk(OFS_PART_HIGH, 8'hC6);
    rdchk(OFS_STOP, 8'h7F);
    rdchk(OFS_START, 8'h00);
    rdchk(OFS_DIR, 8'h00);
    rdchk(OFS_POINTER, 8'h00);
    rdchk(OFS_DIRECT, 8'h00);
    rdchk(OFS_TABLE_LAST, 8'h00);
    rdchk(10'h006, 8'h00);
    $display("test reset_values done");
    // read-only places ignore writes
    wr(OFS_CLASS, 8'hFF);
    wr(OFS_PART_LOW, 8'hFF);
    wr(OFS_PART_HIGH, 8'h00);
    wr(OFS_POINTER, 8'h55);
    rdchk(OFS_CLASS, 8'h5A);
    rdchk(OFS_PART_LOW, 8'h3C);
    rdchk(OFS_PART_HIGH, 8'hC6);
    rdchk(OFS_POINTER, 8'h00);
    // back to back: a write straight before a read, and two reads in a row
    wrrd(OFS_CLASS, 8'hFF, 8'h5A);
    rd2(OFS_PART_LOW, OFS_PART_HIGH, 8'h3C, 8'hC6);
    $display("test read_only done");
    // direct state reaches both sections at once
    wr(OFS_DIRECT, 8'hA5);
    check({4'h0, filt.highpass_section}, 8'h0A);
    check({4'h0, filt.lowpass_section}, 8'h05);
    rdchk(OFS_DIRECT, 8'hA5);
    $display("test direct done");
    // whole table, distinct bytes so an address slip shows
    for (int i = 0; i < TABLE_DEPTH; i++) begin
      shadow[i] = 8'(i * 37 + 5);
      wr(OFS_TABLE_FIRST + 10'(i), shadow[i]);
    end
    for (int i = 0; i < TABLE_DEPTH; i++) begin
      rdchk(OFS_TABLE_FIRST + 10'(i), shadow[i]);
    end
    shadow[TABLE_DEPTH-1] = 8'hE7;
    wrrd(OFS_TABLE_LAST, shadow[TABLE_DEPTH-1], 8'hE7);
    $display("test table done");
    // reserved top bits dropped; start write also loads the pointer
    s_lo = 7'h02;
    s_hi = 7'h04;
    wrrd(OFS_STOP, 8'h84, 8'h04);
    wrrd(OFS_START, 8'h82, 8'h02);
    wr(OFS_DIR, 8'hFE);
    ptr = s_lo;
    rdchk(OFS_STOP, 8'h04);
    rdchk(OFS_START, 8'h02);
    rdchk(OFS_DIR, 8'h00);
    // upward walk wraps from stop back to start
    repeat (4) trig(DIR_INC);
    wr(OFS_DIR, 8'h01);
    rdchk(OFS_DIR, 8'h01);
    // downward walk wraps from start back to stop
    repeat (4) trig(DIR_DEC);
    $display("test sequencing done");
    // second reset in mid-run
    @(posedge clock);
    #1 sys_rst = 1'b1;
    repeat (3) @(posedge clock);
    #1 sys_rst = 1'b0;
    check(filt, BYTE_ZERO);
    rdchk(OFS_STOP, 8'h7F);
    rdchk(OFS_START, 8'h00);
    rdchk(OFS_POINTER, 8'h00);
    rdchk(OFS_TABLE_FIRST + 10'h005, 8'h00);
    $display("test second_reset done");
    complete_run();
  end
endmodule
`default_nettype wire
